/* File: design/cpv_pkg.sv */
// Register map, field layout and state types for the camera preview path config block
package cpv_pkg;
    localparam logic [31:0] CPV_ADDR_TRGFMT = 32'h4f00_007c;
    localparam logic [31:0] CPV_ADDR_DMACTL = 32'h4f00_0080;
    localparam logic [31:0] CPV_ADDR_PRERAT = 32'h4f00_0084;
    localparam logic [31:0] CPV_ADDR_PREDST = 32'h4f00_0088;
    localparam logic [31:0] CPV_ADDR_SCCTRL = 32'h4f00_008c;
    localparam logic [31:0] CPV_ADDR_TAREA = 32'h4f00_0090;
    localparam logic [31:0] CPV_ADDR_STATUS = 32'h4f00_0098;
    localparam logic [31:0] CPV_ADDR_CAPEN = 32'h4f00_00a0;
    localparam logic [31:0] CPV_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] CPV_ZERO = 32'h0000_0000;
    // Writable bit masks; bits outside read as zero
    localparam logic [31:0] CPV_MASK_TRGFMT = 32'h1fff_dfff;
    localparam logic [31:0] CPV_MASK_DMACTL = 32'h00ff_c004;
    localparam logic [31:0] CPV_MASK_PRERAT = 32'hf07f_007f;
    localparam logic [31:0] CPV_MASK_PREDST = 32'h0fff_0fff;
    localparam logic [31:0] CPV_MASK_SCCTRL = 32'hf1ff_81ff;
    localparam logic [31:0] CPV_MASK_TAREA = 32'h03ff_ffff;
    localparam logic [31:0] CPV_MASK_CAPEN = 32'he000_0000;
    localparam int CPV_TW_HI = 28;
    localparam int CPV_TW_LO = 16;
    localparam int CPV_OR_HI = 15;
    localparam int CPV_OR_LO = 14;
    localparam int CPV_LUMA_BIT = 12;
    localparam int CPV_TH_HI = 11;
    localparam int CPV_TH_LO = 0;
    localparam int CPV_MB_HI = 23;
    localparam int CPV_MB_LO = 19;
    localparam int CPV_RB_HI = 18;
    localparam int CPV_RB_LO = 14;
    localparam int CPV_FIRQ_BIT = 2;
    localparam int CPV_SH_HI = 31;
    localparam int CPV_SH_LO = 28;
    localparam int CPV_PH_HI = 22;
    localparam int CPV_PH_LO = 16;
    localparam int CPV_PV_HI = 6;
    localparam int CPV_PV_LO = 0;
    localparam int CPV_OW_HI = 27;
    localparam int CPV_OW_LO = 16;
    localparam int CPV_OH_HI = 11;
    localparam int CPV_OH_LO = 0;
    localparam int CPV_SAMP_BIT = 31;
    localparam int CPV_DEPTH_BIT = 30;
    localparam int CPV_DIR_HI = 29;
    localparam int CPV_DIR_LO = 28;
    localparam int CPV_MH_HI = 24;
    localparam int CPV_MH_LO = 16;
    localparam int CPV_GO_BIT = 15;
    localparam int CPV_MV_HI = 8;
    localparam int CPV_MV_LO = 0;
    localparam int CPV_AREA_HI = 25;
    localparam int CPV_ST_OVCB = 31;
    localparam int CPV_ST_OVCR = 30;
    localparam int CPV_ST_FC_LO = 26;
    localparam int CPV_ST_OR_LO = 23;
    localparam int CPV_ST_CAP = 21;
    localparam int CPV_CE_GLOBAL = 31;
    localparam int CPV_CE_CODEC = 30;
    localparam int CPV_CE_PREV = 29;
    typedef enum logic [1:0] {CPV_BUS_IDLE, CPV_BUS_ACK} cpv_bus_t;
endpackage

/* File: design/cpv_preview_cfg.sv */
// Camera preview path configuration and status registers on Avalon-MM
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
module cpv_preview_cfg
    import cpv_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic frame_done_pin,
    input wire logic blue_chroma_fifo_overflow_pin,
    input wire logic red_chroma_fifo_overflow_pin,
    output logic [12:0] target_width_px,
    output logic [1:0] output_orientation,
    output logic luma_range_select,
    output logic [11:0] target_height_px,
    output logic [4:0] main_burst_len,
    output logic [4:0] remainder_burst_len,
    output logic final_irq,
    output logic [3:0] prescale_shift,
    output logic [6:0] prescale_h_ratio,
    output logic [6:0] prescale_v_ratio,
    output logic [11:0] prescale_out_width,
    output logic [11:0] prescale_out_height,
    output logic conversion_sampling,
    output logic rgb_depth_select,
    output logic [1:0] scale_direction,
    output logic [8:0] main_h_ratio,
    output logic main_scaler_go,
    output logic [8:0] main_v_ratio,
    output logic [25:0] target_area,
    output logic global_capture_on,
    output logic codec_capture_on,
    output logic preview_capture_on
);
    logic [31:0] trgfmt_q, trgfmt_d;
    logic [31:0] dmactl_q, dmactl_d;
    logic [31:0] prerat_q, prerat_d;
    logic [31:0] predst_q, predst_d;
    logic [31:0] scctrl_q, scctrl_d;
    logic [31:0] tarea_q, tarea_d;
    logic [31:0] capen_q, capen_d;
    logic [1:0] frame_cnt_q, frame_cnt_d;
    logic ovcb_q, ovcb_d;
    logic ovcr_q, ovcr_d;
    logic firq_q, firq_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    cpv_bus_t bus_q, bus_d;
    // Two-stage synchronisers for the asynchronous path inputs
    logic [2:0] sync1_q, sync2_q, prev_q;
    logic [2:0] sync_in;
    logic frame_evt;
    logic [31:0] bmask;
    logic [31:0] status_word;
    logic hit;
    logic [31:0] rd_mux;

    assign sync_in = {red_chroma_fifo_overflow_pin, blue_chroma_fifo_overflow_pin, frame_done_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= sync_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi] <= sync2_q[gi];
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_bmask
            assign bmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
        end
    endgenerate

    // Frame end is taken on the rising edge of the synchronised level
    assign frame_evt = sync2_q[0] & ~prev_q[0];

    always_comb begin
        status_word = CPV_ZERO;
        status_word[CPV_ST_OVCB] = ovcb_q;
        status_word[CPV_ST_OVCR] = ovcr_q;
        status_word[CPV_ST_FC_LO +: 2] = frame_cnt_q;
        status_word[CPV_ST_OR_LO +: 2] = trgfmt_q[CPV_OR_HI:CPV_OR_LO];
        status_word[CPV_ST_CAP] = capen_q[CPV_CE_GLOBAL] & capen_q[CPV_CE_PREV];
    end

    always_comb begin
        hit = 1'b1;
        rd_mux = CPV_ZERO;
        unique case (avs_address)
            CPV_ADDR_TRGFMT: rd_mux = trgfmt_q;
            CPV_ADDR_DMACTL: rd_mux = dmactl_q;
            CPV_ADDR_PRERAT: rd_mux = prerat_q;
            CPV_ADDR_PREDST: rd_mux = predst_q;
            CPV_ADDR_SCCTRL: rd_mux = scctrl_q;
            CPV_ADDR_TAREA: rd_mux = tarea_q;
            CPV_ADDR_STATUS: rd_mux = status_word;
            CPV_ADDR_CAPEN: rd_mux = capen_q;
            default: hit = 1'b0;
        endcase
    end

    // Bus: one wait cycle, answer on the second cycle of the request
    always_comb begin
        bus_d = bus_q;
        rdata_d = rdata_q;
        resp_d = resp_q;
        unique case (bus_q)
            CPV_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_d = CPV_BUS_ACK;
                    rdata_d = avs_read ? rd_mux : CPV_ZERO;
                    resp_d = hit ? 2'b00 : 2'b11;
                end
            end
            CPV_BUS_ACK: begin
                bus_d = CPV_BUS_IDLE;
            end
        endcase
    end

    logic wr_now;
    assign wr_now = (bus_q == CPV_BUS_ACK) && avs_write;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk);
        merge = ((old & ~bmask) | (avs_writedata & bmask)) & msk;
    endfunction

    always_comb begin
        trgfmt_d = trgfmt_q;
        dmactl_d = dmactl_q;
        prerat_d = prerat_q;
        predst_d = predst_q;
        scctrl_d = scctrl_q;
        tarea_d = tarea_q;
        capen_d = capen_q;
        if (wr_now) begin
            unique case (avs_address)
                CPV_ADDR_TRGFMT: trgfmt_d = merge(trgfmt_q, CPV_MASK_TRGFMT);
                CPV_ADDR_DMACTL: dmactl_d = merge(dmactl_q, CPV_MASK_DMACTL);
                CPV_ADDR_PRERAT: prerat_d = merge(prerat_q, CPV_MASK_PRERAT);
                CPV_ADDR_PREDST: predst_d = merge(predst_q, CPV_MASK_PREDST);
                CPV_ADDR_SCCTRL: scctrl_d = merge(scctrl_q, CPV_MASK_SCCTRL);
                CPV_ADDR_TAREA: tarea_d = merge(tarea_q, CPV_MASK_TAREA);
                CPV_ADDR_CAPEN: capen_d = merge(capen_q, CPV_MASK_CAPEN);
                default: ; // Status and unmapped writes are dropped
            endcase
        end
        // Frame end self-clears the final request; hardware clear beats a same-cycle write
        if (frame_evt && dmactl_q[CPV_FIRQ_BIT]) begin
            dmactl_d[CPV_FIRQ_BIT] = 1'b0;
        end
    end

    always_comb begin
        frame_cnt_d = frame_cnt_q;
        ovcb_d = ovcb_q | sync2_q[1];
        ovcr_d = ovcr_q | sync2_q[2];
        firq_d = frame_evt && dmactl_q[CPV_FIRQ_BIT];
        if (frame_evt && capen_q[CPV_CE_GLOBAL] && capen_q[CPV_CE_PREV]) begin
            frame_cnt_d = frame_cnt_q + 2'd1;
        end
        // Dropping capture clears overflow history; an overflow in that cycle still lands
        if (wr_now && avs_address == CPV_ADDR_CAPEN && bmask[CPV_CE_GLOBAL]
                && !avs_writedata[CPV_CE_GLOBAL]) begin
            frame_cnt_d = 2'd0;
            ovcb_d = sync2_q[1];
            ovcr_d = sync2_q[2];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            trgfmt_q <= CPV_RESET_VAL;
            dmactl_q <= CPV_RESET_VAL;
            prerat_q <= CPV_RESET_VAL;
            predst_q <= CPV_RESET_VAL;
            scctrl_q <= CPV_RESET_VAL;
            tarea_q <= CPV_RESET_VAL;
            capen_q <= CPV_RESET_VAL;
            frame_cnt_q <= 2'd0;
            ovcb_q <= 1'b0;
            ovcr_q <= 1'b0;
            firq_q <= 1'b0;
            rdata_q <= CPV_ZERO;
            resp_q <= 2'b00;
            bus_q <= CPV_BUS_IDLE;
        end else begin
            trgfmt_q <= trgfmt_d;
            dmactl_q <= dmactl_d;
            prerat_q <= prerat_d;
            predst_q <= predst_d;
            scctrl_q <= scctrl_d;
            tarea_q <= tarea_d;
            capen_q <= capen_d;
            frame_cnt_q <= frame_cnt_d;
            ovcb_q <= ovcb_d;
            ovcr_q <= ovcr_d;
            firq_q <= firq_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            bus_q <= bus_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && (bus_q != CPV_BUS_ACK);
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;
    assign final_irq = firq_q;
    assign target_width_px = trgfmt_q[CPV_TW_HI:CPV_TW_LO];
    assign output_orientation = trgfmt_q[CPV_OR_HI:CPV_OR_LO];
    assign luma_range_select = trgfmt_q[CPV_LUMA_BIT];
    assign target_height_px = trgfmt_q[CPV_TH_HI:CPV_TH_LO];
    assign main_burst_len = dmactl_q[CPV_MB_HI:CPV_MB_LO];
    assign remainder_burst_len = dmactl_q[CPV_RB_HI:CPV_RB_LO];
    assign prescale_shift = prerat_q[CPV_SH_HI:CPV_SH_LO];
    assign prescale_h_ratio = prerat_q[CPV_PH_HI:CPV_PH_LO];
    assign prescale_v_ratio = prerat_q[CPV_PV_HI:CPV_PV_LO];
    assign prescale_out_width = predst_q[CPV_OW_HI:CPV_OW_LO];
    assign prescale_out_height = predst_q[CPV_OH_HI:CPV_OH_LO];
    assign conversion_sampling = scctrl_q[CPV_SAMP_BIT];
    assign rgb_depth_select = scctrl_q[CPV_DEPTH_BIT];
    assign scale_direction = scctrl_q[CPV_DIR_HI:CPV_DIR_LO];
    assign main_h_ratio = scctrl_q[CPV_MH_HI:CPV_MH_LO];
    assign main_scaler_go = scctrl_q[CPV_GO_BIT];
    assign main_v_ratio = scctrl_q[CPV_MV_HI:CPV_MV_LO];
    assign target_area = tarea_q[CPV_AREA_HI:0];
    assign global_capture_on = capen_q[CPV_CE_GLOBAL];
    assign codec_capture_on = capen_q[CPV_CE_CODEC];
    assign preview_capture_on = capen_q[CPV_CE_PREV];
endmodule

/* File: bench/cpv_sva.sv */
// Port-level assertions for the preview path configuration block
`timescale 1ns/1ns
module cpv_sva
    import cpv_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic frame_done_pin,
    input wire logic final_irq,
    input wire logic [12:0] target_width_px,
    input wire logic [1:0] output_orientation,
    input wire logic [4:0] main_burst_len,
    input wire logic rgb_depth_select,
    input wire logic main_scaler_go,
    input wire logic preview_capture_on
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic req, wr_done, mapped;
    logic [3:0] since_q, since_d;
    assign req = avs_read || avs_write;
    assign wr_done = avs_write && !avs_waitrequest;
    assign mapped = avs_address inside {CPV_ADDR_TRGFMT, CPV_ADDR_DMACTL, CPV_ADDR_PRERAT,
        CPV_ADDR_PREDST, CPV_ADDR_SCCTRL, CPV_ADDR_TAREA, CPV_ADDR_STATUS, CPV_ADDR_CAPEN};
    // Saturating age of the last frame-end level, so a stray pulse is caught
    always_comb since_d = frame_done_pin ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
    always_ff @(posedge clock) since_q <= rst_b ? since_d : 4'hf;
    sequence s_wait;
        req && avs_waitrequest;
    endsequence
    sequence s_fmt_wr;
        wr_done && avs_address == CPV_ADDR_TRGFMT;
    endsequence
    property p_fmt;
        s_fmt_wr |=> {target_width_px, output_orientation} == $past(avs_writedata[28:14]);
    endproperty
    property p_burst;
        wr_done && avs_address == CPV_ADDR_DMACTL
            |=> main_burst_len == $past(avs_writedata[23:19]);
    endproperty
    property p_scctl;
        wr_done && avs_address == CPV_ADDR_SCCTRL
            |=> {rgb_depth_select, main_scaler_go}
                == {$past(avs_writedata[30]), $past(avs_writedata[15])};
    endproperty
    a_one_wait: assert property (s_wait |=> !avs_waitrequest) else $error("no answer");
    a_first_wait: assert property ($rose(req) |-> s_wait) else $error("zero wait");
    a_bad_resp: assert property (req && !avs_waitrequest && !mapped |-> avs_response == 2'b11)
        else $error("unmapped not flagged");
    a_fmt_write: assert property (p_fmt) else $error("format fields");
    a_burst_write: assert property (p_burst) else $error("burst field");
    a_depth_go: assert property (p_scctl) else $error("scaler fields");
    a_capen_write: assert property (wr_done && avs_address == CPV_ADDR_CAPEN
        |=> preview_capture_on == $past(avs_writedata[29])) else $error("capture");
    a_irq_pulse: assert property (final_irq |=> !final_irq) else $error("irq width");
    a_irq_cause: assert property (final_irq |-> since_q <= 4'h6) else $error("stray irq");
endmodule

bind cpv_preview_cfg cpv_sva u_cpv_sva (.*);

/* File: bench/cpv_cam_model.sv */
// Camera-side model: end-of-frame and source FIFO overflow levels
`timescale 1ns/1ns
module cpv_cam_model (
    input wire logic clock,
    output logic frame_done_pin,
    output logic blue_chroma_fifo_overflow_pin,
    output logic red_chroma_fifo_overflow_pin
);
    initial {blue_chroma_fifo_overflow_pin, red_chroma_fifo_overflow_pin, frame_done_pin} = 3'h0;
    // Held three cycles so the two-stage synchroniser cannot miss the level
    task automatic pulse(input logic [2:0] which);
        @(posedge clock);
        {blue_chroma_fifo_overflow_pin, red_chroma_fifo_overflow_pin, frame_done_pin} <= which;
        repeat (3) @(posedge clock);
        {blue_chroma_fifo_overflow_pin, red_chroma_fifo_overflow_pin, frame_done_pin} <= 3'h0;
    endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the preview path configuration block
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected %0t: got %h want %h", $time, a, b); end end
module tb_top;
    import cpv_pkg::*;
    localparam logic [31:0] ADR [7] = '{CPV_ADDR_TRGFMT, CPV_ADDR_DMACTL, CPV_ADDR_PRERAT,
        CPV_ADDR_PREDST, CPV_ADDR_SCCTRL, CPV_ADDR_TAREA, CPV_ADDR_CAPEN};
    localparam logic [31:0] MSK [7] = '{CPV_MASK_TRGFMT, CPV_MASK_DMACTL, CPV_MASK_PRERAT,
        CPV_MASK_PREDST, CPV_MASK_SCCTRL, CPV_MASK_TAREA, CPV_MASK_CAPEN};
    logic clock, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest, final_irq;
    logic luma_range_select, conversion_sampling, rgb_depth_select, main_scaler_go;
    logic global_capture_on, codec_capture_on, preview_capture_on, frame_done_pin;
    logic blue_chroma_fifo_overflow_pin, red_chroma_fifo_overflow_pin;
    logic [31:0] avs_address = 0, avs_writedata = 0, avs_readdata, wd [7];
    logic [3:0] avs_byteenable = 4'hf, prescale_shift;
    logic [1:0] avs_response, output_orientation, scale_direction;
    logic [12:0] target_width_px;
    logic [11:0] target_height_px, prescale_out_width, prescale_out_height;
    logic [4:0] main_burst_len, remainder_burst_len;
    logic [6:0] prescale_h_ratio, prescale_v_ratio;
    logic [8:0] main_h_ratio, main_v_ratio;
    logic [25:0] target_area;
    logic [33:0] expq [$];
    logic [33:0] exp_v;
    int errors = 0, total_checks = 0, n;
    cpv_preview_cfg u_cpv_preview_cfg (.*);
    cpv_cam_model u_cpv_cam_model (.*);
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    function automatic logic [33:0] st(logic [1:0] ov, logic [1:0] fc, logic [1:0] o, logic c);
        st = {2'b00, ov, 2'b00, fc, 1'b0, o, 1'b0, c, 21'h0};
    endfunction
    task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // Hold the request until the rising edge that sees the answer; a hang is the watchdog's
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        expq.push_back(e);
        acc(a, 0, 0);
    endtask
    task automatic close_out();
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            exp_v = expq.pop_front();
            `CHK({avs_response, avs_readdata}, exp_v)
        end
    end
    initial begin
        #300000;
        errors++;
        close_out();
    end
    initial begin
        void'($urandom(52587));
        repeat (12) @(posedge clock);
        rst_b <= 1;
        foreach (ADR[i]) rd(ADR[i], 34'h0);
        rd(CPV_ADDR_STATUS, 34'h0);
        for (int p = 0; p < 3; p++) begin
            foreach (wd[i]) wd[i] = $urandom;
            wd[0][16] = 1'b0;
            wd[1][23:14] = {5'h1 << ($urandom % 4 + 1), 5'h1 << ($urandom % 4 + 1)};
            wd[4][31] = 1'b1;
            wd[4][29:28] = {2{wd[4][28]}};
            wd[5] = wd[0][28:16] * wd[0][11:0];
            wd[6][31] = 1'b1;
            foreach (wd[i]) acc(ADR[i], 1, wd[i]);
            @(negedge clock);
            `CHK({target_width_px, output_orientation, luma_range_select, target_height_px}, {wd[0][28:14], wd[0][12:0]})
            `CHK({main_burst_len, remainder_burst_len}, wd[1][23:14])
            `CHK({prescale_shift, prescale_h_ratio, prescale_v_ratio}, {wd[2][31:28], wd[2][22:16], wd[2][6:0]})
            `CHK({prescale_out_width, prescale_out_height}, {wd[3][27:16], wd[3][11:0]})
            `CHK({conversion_sampling, rgb_depth_select, scale_direction, main_h_ratio, main_scaler_go, main_v_ratio}, {wd[4][31:28], wd[4][24:15], wd[4][8:0]})
            `CHK(target_area, wd[5][25:0])
            `CHK({global_capture_on, codec_capture_on, preview_capture_on}, wd[6][31:29])
            foreach (ADR[i]) rd(ADR[i], {2'b00, wd[i] & MSK[i]});
            acc(CPV_ADDR_STATUS, 1, $urandom);
            rd(CPV_ADDR_STATUS, st(2'b00, 2'b00, wd[0][15:14], wd[6][29]));
        end
        avs_byteenable <= 4'h5;
        acc(CPV_ADDR_PREDST, 1, ~wd[3]);
        avs_byteenable <= 4'hf;
        // Only byte lanes 0 and 2 took the inverted data
        wd[3] = MSK[3] & (~wd[3] & 32'h00ff_00ff | wd[3] & 32'hff00_ff00);
        rd(CPV_ADDR_PREDST, {2'b00, wd[3]});
        acc(CPV_ADDR_DMACTL, 1, wd[1] | 32'h0000_0004);
        acc(CPV_ADDR_CAPEN, 1, 32'ha000_0000);
        for (int f = 1; f < 6; f++) begin
            u_cpv_cam_model.pulse(3'b001);
            n = 0;
            while (final_irq !== 1'b1 && n < 12) begin @(negedge clock); n++; end
            `CHK(final_irq, 1'(f == 1))
            rd(CPV_ADDR_DMACTL, {2'b00, wd[1] & MSK[1] & 32'hffff_fffb});
            rd(CPV_ADDR_STATUS, st(2'b00, 2'(f), wd[0][15:14], 1'b1));
        end
        u_cpv_cam_model.pulse(3'b110);
        repeat (6) @(posedge clock);
        rd(CPV_ADDR_STATUS, st(2'b11, 2'b01, wd[0][15:14], 1'b1));
        acc(CPV_ADDR_CAPEN, 1, 32'h0000_0000);
        rd(CPV_ADDR_STATUS, st(2'b00, 2'b00, wd[0][15:14], 1'b0));
        // Bypass-style setting: global on, both scaler enables kept at zero
        acc(CPV_ADDR_CAPEN, 1, 32'h8000_0000);
        u_cpv_cam_model.pulse(3'b001);
        repeat (4) @(negedge clock);
        `CHK({global_capture_on, codec_capture_on, preview_capture_on}, 3'b100)
        rd(CPV_ADDR_STATUS, st(2'b00, 2'b00, wd[0][15:14], 1'b0));
        acc(32'h4f00_0094, 1, 32'hffff_ffff);
        rd(32'h4f00_0094, {2'b11, 32'h0000_0000});
        @(posedge clock);
        rst_b <= 0;
        repeat (2) @(posedge clock);
        rst_b <= 1;
        rd(CPV_ADDR_TRGFMT, 34'h0);
        repeat (4) @(posedge clock);
        close_out();
    end
endmodule
